// file: shared/dapr_cfg.svh
`ifndef DAPR_CFG_SVH
`define DAPR_CFG_SVH

// register byte offsets
`define DAPR_OFF_PTR_HI 12'hDF0
`define DAPR_OFF_PTR_LO 12'hDF8
`define DAPR_OFF_PERM 12'hFB8
`define DAPR_OFF_CTRL 12'hD00

// permission status field positions (low bit of each two-bit field)
`define DAPR_POS_ROOT_NI 26
`define DAPR_POS_ROOT_I 24
`define DAPR_POS_REALM_NI 14
`define DAPR_POS_REALM_I 12
`define DAPR_POS_SEC_NI 6
`define DAPR_POS_SEC_I 4
`define DAPR_POS_OPEN_NI 2
`define DAPR_POS_OPEN_I 0

// control word bit positions
`define DAPR_CTRL_OPEN_EN 0
`define DAPR_CTRL_SEC_EN 1
`define DAPR_CTRL_ROOT_EN 2
`define DAPR_CTRL_REALM_EN 3

// pointer low word format bits
`define DAPR_PTR_FMT_BIT 1
`define DAPR_PTR_PRES_BIT 0

// reset values
`define DAPR_CTRL_RESET 4'h0

`endif

// file: shared/dapr_pkg.sv
package dapr_pkg;

  // two-bit debug state encoding; 2'b01 is never produced
  typedef enum logic [1:0] {
    DAPR_ST_ABSENT = 2'b00,
    DAPR_ST_RSVD = 2'b01,
    DAPR_ST_OFF = 2'b10,
    DAPR_ST_ON = 2'b11
  } dapr_state_t;

  typedef enum logic [1:0] {
    DAPR_PH_IDLE,
    DAPR_PH_SETUP,
    DAPR_PH_ACCESS
  } dapr_phase_t;

endpackage

// file: verilog/dapr_regs.sv
// Behaviour
// RL1 - permission status word, top four bits zero
// RL2 - root fields: absent, off, on
// RL3 - realm fields: absent, off, on
// RL4 - unprivileged and hypervisor fields always zero
// RL5 - secure fields on when secure enable set
// RL6 - secure fields off or absent otherwise
// RL7 - open fields on when port enable set
// RL8 - open fields off otherwise; 01 never used
// RL9 - pointer low and high words, high zero; here high reads POINTER_PAGE[51:20] unless WIDE_POINTER is clear
// RL10 - pointer holds upper address bits only
// RL11 - pointer low bits 11 to 2 zero
// RL12 - pointer format bit reads one
// RL13 - presence bit shows attached debug entry
// RL14 - pointer targets component or table page
// RL15 - debugger reads ident words via transfer address
// RL16 - debugger treats bad pointers as non-fatal
// RL17 - pointer is an open-space address
// RL18 - status reads side-effect free, writes ignored
`timescale 1ns/1ns
`include "dapr_cfg.svh"

module dapr_regs
  import dapr_pkg::*;
#(
  parameter bit HAS_REALM = 1'b1,
  parameter bit HAS_SECURE = 1'b1,
  parameter bit WIDE_POINTER = 1'b1,
  parameter bit ENTRY_PRESENT = 1'b1,
  // arbitrary default: page of the component or its table, open address space
  parameter logic [51:0] POINTER_PAGE = 52'h0_0000_E00F_F
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic port_access_enable,
  output logic secure_access_enable
);

  // control word and captured read data
  logic [3:0] ctrl_q;
  logic [3:0] ctrl_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  // assembled read words
  logic [31:0] perm_word;
  logic [31:0] ptr_lo;
  logic [31:0] ptr_hi;
  logic [31:0] ctrl_word;
  // pointer page slices
  logic [19:0] page_lo;
  logic [31:0] page_hi;
  // per-domain debug state
  dapr_state_t root_st;
  dapr_state_t realm_st;
  dapr_state_t sec_st;
  dapr_state_t open_st;
  // field table feeding the permission word
  dapr_state_t field_st [8];
  logic [31:0] field_word [8];
  // bus phase tracking
  dapr_phase_t phase_q;
  dapr_phase_t phase_d;
  logic rd_setup;
  logic access_cyc;
  logic wr_take;
  // address decode
  logic hit_perm;
  logic hit_ptr_lo;
  logic hit_ptr_hi;
  logic hit_ctrl;
  logic ctrl_wr;
  // enables held in the control word
  logic root_en;
  logic realm_en;
  logic sec_en;
  logic open_en;

  // low bit of each two-bit field, in field table order
  localparam int FIELD_POS [8] = '{
    `DAPR_POS_ROOT_NI,
    `DAPR_POS_ROOT_I,
    `DAPR_POS_REALM_NI,
    `DAPR_POS_REALM_I,
    `DAPR_POS_SEC_NI,
    `DAPR_POS_SEC_I,
    `DAPR_POS_OPEN_NI,
    `DAPR_POS_OPEN_I
  };

  // zero wait states: every access phase completes at once
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = rdata_q;

  // cycle classes; clk_en low means nothing is taken
  assign rd_setup = clk_en & psel & ~penable & ~pwrite;
  assign access_cyc = psel & penable & (phase_q == DAPR_PH_SETUP);
  assign wr_take = clk_en & access_cyc & pwrite;

  // phase follower; only a setup seen last cycle opens an access
  always_comb begin
    case (phase_q)
      DAPR_PH_IDLE: begin
        if (psel && !penable) begin
          phase_d = DAPR_PH_SETUP;
        end else begin
          phase_d = DAPR_PH_IDLE;
        end
      end
      DAPR_PH_SETUP: begin
        if (psel && penable) begin
          phase_d = DAPR_PH_ACCESS;
        end else if (psel) begin
          phase_d = DAPR_PH_SETUP;
        end else begin
          phase_d = DAPR_PH_IDLE;
        end
      end
      DAPR_PH_ACCESS: begin
        // pready is always high, so an access never stretches
        if (psel && !penable) begin
          phase_d = DAPR_PH_SETUP;
        end else begin
          phase_d = DAPR_PH_IDLE;
        end
      end
      default: begin
        phase_d = DAPR_PH_IDLE;
      end
    endcase
  end

  // phase register; frozen with the rest while clk_en is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= DAPR_PH_IDLE;
    end else if (clk_en) begin
      phase_q <= phase_d;
    end
  end

  // status and pointer offsets
  always_comb begin
    hit_perm = (paddr == `DAPR_OFF_PERM);
    hit_ptr_lo = (paddr == `DAPR_OFF_PTR_LO);
    hit_ptr_hi = (paddr == `DAPR_OFF_PTR_HI);
  end

  // control offset
  always_comb begin
    hit_ctrl = (paddr == `DAPR_OFF_CTRL);
  end

  // only the control word takes writes; status and pointer ignore them
  assign ctrl_wr = wr_take & hit_ctrl & pstrb[0]; // see RL18

  // control next value
  always_comb begin
    ctrl_d = ctrl_q;
    // upper write data bits have no home and are dropped
    if (ctrl_wr) begin
      ctrl_d = pwdata[3:0];
    end
  end

  // control word: only register that software can change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `DAPR_CTRL_RESET;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
    end
  end

  // enable bits of the control word
  assign open_en = ctrl_q[`DAPR_CTRL_OPEN_EN];
  assign sec_en = ctrl_q[`DAPR_CTRL_SEC_EN];
  assign root_en = ctrl_q[`DAPR_CTRL_ROOT_EN];
  assign realm_en = ctrl_q[`DAPR_CTRL_REALM_EN];
  assign port_access_enable = open_en;
  assign secure_access_enable = sec_en;

  // page slices of the fixed pointer
  assign page_lo = POINTER_PAGE[19:0];
  assign page_hi = POINTER_PAGE[51:20];

  // root state; without the optional world the field reads absent
  always_comb begin
    case ({HAS_REALM, root_en})
      2'b11: begin
        root_st = DAPR_ST_ON; // see RL2
      end
      2'b10: begin
        root_st = DAPR_ST_OFF; // see RL2
      end
      default: begin
        root_st = DAPR_ST_ABSENT; // see RL2
      end
    endcase
  end

  // realm state, same shape as root
  always_comb begin
    case ({HAS_REALM, realm_en})
      2'b11: begin
        realm_st = DAPR_ST_ON; // see RL3
      end
      2'b10: begin
        realm_st = DAPR_ST_OFF; // see RL3
      end
      default: begin
        realm_st = DAPR_ST_ABSENT; // see RL3
      end
    endcase
  end

  // secure state; an enable without secure support still reads absent
  always_comb begin
    case ({HAS_SECURE, sec_en})
      2'b11: begin
        sec_st = DAPR_ST_ON; // see RL5
      end
      2'b10: begin
        sec_st = DAPR_ST_OFF; // see RL6
      end
      default: begin
        sec_st = DAPR_ST_ABSENT; // see RL6
      end
    endcase
  end

  // open state; always implemented, so never absent
  always_comb begin
    case (open_en)
      1'b1: begin
        open_st = DAPR_ST_ON; // see RL7
      end
      default: begin
        open_st = DAPR_ST_OFF; // see RL8
      end
    endcase
  end

  // field table; invasive and non-invasive share one state per domain
  always_comb begin
    field_st[0] = root_st;
    field_st[1] = root_st;
    field_st[2] = realm_st;
    field_st[3] = realm_st;
    field_st[4] = sec_st;
    field_st[5] = sec_st;
    field_st[6] = open_st;
    field_st[7] = open_st;
  end

  // one shifted word per field; the fields never overlap
  for (genvar g = 0; g < 8; g++) begin : gen_field
    dapr_state_t safe_st;
    // the reserved code can never leave the port, whatever feeds the table
    always_comb begin
      case (field_st[g])
        DAPR_ST_ON: begin
          safe_st = DAPR_ST_ON;
        end
        DAPR_ST_OFF: begin
          safe_st = DAPR_ST_OFF;
        end
        default: begin
          safe_st = DAPR_ST_ABSENT; // see RL8
        end
      endcase
    end
    assign field_word[g] = {30'h0, safe_st} << FIELD_POS[g];
  end

  // merge fields; bits outside them stay zero
  always_comb begin
    perm_word = 32'h0000_0000; // see RL1 see RL4
    for (int f = 0; f < 8; f++) begin
      perm_word = perm_word | field_word[f];
    end
  end

  // pointer low word; low twelve address bits are implied zero
  always_comb begin
    ptr_lo = 32'h0000_0000; // see RL11
    ptr_lo[31:12] = page_lo; // see RL10 see RL14 see RL17
    ptr_lo[`DAPR_PTR_FMT_BIT] = 1'b1; // see RL12
    ptr_lo[`DAPR_PTR_PRES_BIT] = ENTRY_PRESENT; // see RL13
  end

  // pointer high word; a narrow pointer reads zero here
  always_comb begin
    if (WIDE_POINTER) begin
      ptr_hi = page_hi; // see RL9
    end else begin
      ptr_hi = 32'h0000_0000; // see RL9
    end
  end

  // control word as read back
  assign ctrl_word = {28'h000_0000, ctrl_q};

  // read mux; unmapped offsets read zero
  always_comb begin
    // decodes are exact compares, so at most one hit is ever set
    case ({hit_perm, hit_ptr_lo, hit_ptr_hi, hit_ctrl})
      4'b1000: begin
        rdata_d = perm_word;
      end
      4'b0100: begin
        rdata_d = ptr_lo;
      end
      4'b0010: begin
        rdata_d = ptr_hi;
      end
      4'b0001: begin
        rdata_d = ctrl_word;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // capture in setup so data stands through the access phase; no side effects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      rdata_q <= rdata_d; // see RL18
    end
  end

endmodule

// file: testbench/dapr_regs_monitor.sv
`timescale 1ns/1ns
module dapr_regs_monitor #(parameter logic [51:0] POINTER_PAGE = 52'h0) (
  input wire logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] pstrb,
  input wire logic port_access_enable, secure_access_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ctrl write edge, the only moment the enables may move
  wire wc = psel && penable && pwrite && clk_en && paddr == 12'hD00;
  // read data lands at the setup edge, so it is judged one edge on
  sequence rd(a);
    psel && !penable && !pwrite && clk_en && paddr == a;
  endsequence
  perm_zero_a: assert property (rd(12'hFB8) |=> !(prdata & 32'hF0FF0F00))
    else $error("perm zero bits");
  perm_root_a: assert property (rd(12'hFB8) |=> prdata[27:24] inside {4'hA, 4'hF} &&
    prdata[15:12] inside {4'hA, 4'hF}) else $error("perm root realm");
  perm_sec_a: assert property (rd(12'hFB8) |=>
    prdata[7:4] == (secure_access_enable ? 4'hF : 4'hA)) else $error("perm secure");
  perm_open_a: assert property (rd(12'hFB8) |=>
    prdata[3:0] == (port_access_enable ? 4'hF : 4'hA)) else $error("perm open");
  ptr_low_a: assert property (rd(12'hDF8) |=>
    prdata == {POINTER_PAGE[19:0], 12'h003}) else $error("pointer low");
  ptr_high_a: assert property (rd(12'hDF0) |=> prdata == POINTER_PAGE[51:20])
    else $error("pointer high");
  ctrl_hold_a: assert property (!wc |=> $stable({port_access_enable, secure_access_enable}))
    else $error("enables moved");
  ctrl_write_a: assert property (wc && pstrb[0] |=> port_access_enable == $past(pwdata[0]) &&
    secure_access_enable == $past(pwdata[1])) else $error("ctrl write");
endmodule
bind dapr_regs dapr_regs_monitor #(.POINTER_PAGE(POINTER_PAGE)) dapr_regs_monitor_inst (.*);

// file: testbench/dapr_dbg_model.sv
`timescale 1ns/1ns
module dapr_dbg_model (
  input wire logic pclk, pready,
  input wire logic [31:0] prdata,
  output logic clk_en, psel, penable, pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  // idle bus, full strobes
  initial {clk_en, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 44'h0, 4'hF};
  // request held until pready is seen; released data flips so stale values never match
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    {psel, penable, pwdata} <= {2'b00, ~d};
  endtask
  // a transfer with the clock enable low must leave no trace
  task automatic frozen(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    @(posedge pclk);
    clk_en <= 1'b0;
    xfer(1'b1, a, d, x);
    @(posedge pclk);
    clk_en <= 1'b1;
  endtask
endmodule

// file: testbench/tb_dapr_regs.sv
`timescale 1ns/1ns
module tb_dapr_regs;
  localparam logic [51:0] PP = 52'hABCDE_F0123_456;
  logic pclk = 0, presetn = 0, clk_en, psel, penable, pwrite, pready, pslverr;
  logic port_access_enable, secure_access_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, c;
  logic [3:0] pstrb;
  int error_cnt = 0, check_count = 0, cyc = 0;
  always #25 pclk = ~pclk;
  dapr_regs #(.POINTER_PAGE(PP)) dapr_regs_inst (.*);
  dapr_dbg_model dapr_dbg_model_inst (.*);
  function automatic logic [31:0] exp_perm(input logic [3:0] k);
    exp_perm = {4'h0, k[2] ? 4'hF : 4'hA, 8'h00, k[3] ? 4'hF : 4'hA, 4'h0,
      k[1] ? 4'hF : 4'hA, k[0] ? 4'hF : 4'hA};
  endfunction
  // identity word n of the attached component sits at offset FF0 plus 4n inside its page
  function automatic logic [31:0] ident_addr(input logic [31:0] ptr, input int n);
    ident_addr = {ptr[31:12], 12'hFF0} + 32'(4 * n);
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    dapr_dbg_model_inst.xfer(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    dapr_dbg_model_inst.xfer(1'b0, a, 32'h0, r);
    cmp(r, e);
  endtask
  task automatic conclude;
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard, run needs about 520 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      conclude();
    end
  end
  // all-off and all-on control first, then random control words
  initial begin
    void'($urandom(56431));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      c = (i < 2) ? {32{i[0]}} : $urandom;
      wr(12'hD00, c);
      wr(12'hFB8, $urandom);
      wr(12'hDF8, $urandom);
      rc(12'hFB8, exp_perm(c[3:0]));
      dapr_dbg_model_inst.frozen(12'hD00, ~c);
      cmp({secure_access_enable, port_access_enable}, c[1:0]);
      cmp({pready, pslverr}, 2'b10);
      rc(12'hDF8, {PP[19:0], 12'h003});
      cmp(ident_addr(r, 3), {PP[19:0], 12'hFFC});
      rc(12'hDF0, PP[51:20]);
      rc(12'h004, 32'h0);
    end
    conclude();
  end
endmodule
